// ---- xag_cpu.sv ----
// cpu core model driving register and instruction strobes of the address generator
`timescale 1ns/100ps
`default_nettype none
`include "xag_map.svh"

module xag_cpu
   import xag_pkg::*;
(
   input  wire logic        ref_clk_i,
   output var  logic [7:0]  sfr_addr_o,
   output var  logic        sfr_wr_o,
   output var  logic        sfr_rd_o,
   output var  logic [7:0]  sfr_wdata_o,
   output var  logic        op_valid_o,
   output var  xag_op_t     op_o,
   output var  logic [15:0] const16_o,
   output var  logic [7:0]  acc_o,
   output var  logic [7:0]  ri_o,
   output var  logic [7:0]  wdata_o
);
   initial begin
      {sfr_addr_o, sfr_wr_o, sfr_rd_o, sfr_wdata_o, op_valid_o} = '0;
      {const16_o, acc_o, ri_o, wdata_o} = '0;
      op_o = XAG_OP_NONE;
   end

   // one strobe cycle, then the data lines no longer carry the old byte
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_o  <= a;
      sfr_wdata_o <= (a == `XAG_OFS_PAGE_SEL) ? (d & 8'h03) : d;
      sfr_wr_o    <= wr;
      sfr_rd_o    <= !wr;
      @(posedge ref_clk_i);
      sfr_wr_o    <= 1'b0;
      sfr_rd_o    <= 1'b0;
      sfr_wdata_o <= ~sfr_wdata_o;
      #1;
   endtask : bus

   task automatic op(input xag_op_t o, input logic [15:0] c, input logic [7:0] a, input logic [7:0] r,
                     input logic [7:0] d);
      @(posedge ref_clk_i);
      op_o       <= o;
      const16_o  <= c;
      acc_o      <= a;
      ri_o       <= r;
      wdata_o    <= d;
      op_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      op_valid_o <= 1'b0;
      op_o       <= XAG_OP_NONE;
      wdata_o    <= ~wdata_o;
      #1;
   endtask : op

   // register write then read of the same address on the very next edge
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_o  <= a;
      sfr_wdata_o <= d;
      sfr_wr_o    <= 1'b1;
      @(posedge ref_clk_i);
      sfr_wr_o    <= 1'b0;
      sfr_rd_o    <= 1'b1;
      @(posedge ref_clk_i);
      sfr_rd_o    <= 1'b0;
      sfr_wdata_o <= ~d;
      #1;
   endtask : wr_rd

   // two instructions on consecutive edges, valid held high between them
   task automatic op2(input xag_op_t o1, input logic [7:0] r1, input logic [7:0] d, input xag_op_t o2,
                      input logic [7:0] r2);
      @(posedge ref_clk_i);
      op_o       <= o1;
      ri_o       <= r1;
      wdata_o    <= d;
      op_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      op_o       <= o2;
      ri_o       <= r2;
      wdata_o    <= ~d;
      @(posedge ref_clk_i);
      op_valid_o <= 1'b0;
      op_o       <= XAG_OP_NONE;
      #1;
   endtask : op2
endmodule : xag_cpu

`default_nettype wire

// ---- xag_map.svh ----
// register offsets, reset values, field positions and sizes of the address generator
`ifndef XAG_MAP_SVH
`define XAG_MAP_SVH

`define XAG_OFS_PTR_LOW      8'h82
`define XAG_OFS_PTR_HIGH     8'h83
`define XAG_OFS_PAGE_SEL     8'h8f
`define XAG_OFS_AUX_CTRL_ONE 8'ha2

`define XAG_RST_PTR          16'h0000
`define XAG_RST_PAGE_SEL     2'h0
`define XAG_RST_BANK_SEL     1'b0
`define XAG_RST_AUX_SPARE    2'h0
`define XAG_RST_BYTE         8'h00

`define XAG_AUX_BANK_SEL_BIT 0
`define XAG_AUX_SPARE_LSB    4
`define XAG_AUX_SPARE_MSB    5
`define XAG_PAGE_SEL_MSB     1

`define XAG_RAM_BYTES        768
`define XAG_RAM_LIMIT        16'h0300
`define XAG_RAM_AW           10

`endif

// ---- xag_pkg.sv ----
// types shared by the address generator modules
`default_nettype none

package xag_pkg;

   typedef enum logic [3:0] {
      XAG_OP_NONE,
      XAG_OP_PTR_INC,
      XAG_OP_PTR_LOAD,
      XAG_OP_CODE_RD,
      XAG_OP_PTR_RD,
      XAG_OP_PTR_WR,
      XAG_OP_REG_RD,
      XAG_OP_REG_WR,
      XAG_OP_JMP_IND
   } xag_op_t;

endpackage : xag_pkg

`default_nettype wire

// ---- xag_ram.sv ----
// 768-byte expanded data ram held in flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "xag_map.svh"

module xag_ram
   import xag_pkg::*;
(
   input  wire logic ref_clk_i,
   xag_ram_if.mem    ram
);

   logic [7:0] mem_q [`XAG_RAM_BYTES];

   // one store serves both addressing forms
   always_ff @(posedge ref_clk_i) begin
      if (ram.we && (ram.addr < `XAG_RAM_AW'(`XAG_RAM_BYTES))) begin
         mem_q[ram.addr] <= ram.wdata;
      end
   end

   // indices past the last byte never reach the array
   assign ram.rdata = (ram.addr < `XAG_RAM_AW'(`XAG_RAM_BYTES)) ? mem_q[ram.addr] : `XAG_RST_BYTE;

endmodule : xag_ram

`default_nettype wire

// ---- xag_ram_if.sv ----
// port bundle between the address generator and its byte storage
`timescale 1ns/100ps
`default_nettype none
`include "xag_map.svh"

interface xag_ram_if;
   logic                      we;
   logic [`XAG_RAM_AW-1:0]    addr;
   logic [7:0]                wdata;
   logic [7:0]                rdata;

   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface : xag_ram_if

`default_nettype wire

// ---- xag_top.sv ----
// expanded data ram address generation with dual data pointer and page select
//
// Function
// - 768 bytes at 0000h-02ffh, indirect moves only
// - register form: page high byte, ri low
// - pointer form uses selected pointer, read/write
// - two pointers, aux bit 0 selects
// - six pointer instructions use selected pointer
// - low byte register maps selected pointer low
// - high byte register at 0x83, resets zero
// - page bits 1-0 choose one of three pages
// - paged and pointer space share storage
`timescale 1ns/100ps
`default_nettype none
`include "xag_map.svh"

module xag_top
   import xag_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic        op_valid_i,
   input  wire xag_op_t     op_i,
   input  wire logic [15:0] const16_i,
   input  wire logic [7:0]  acc_i,
   input  wire logic [7:0]  ri_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       sfr_rdata_o,
   output logic [7:0]       expanded_data_ram_rdata_o,
   output logic             expanded_data_ram_rvalid_o,
   output logic [15:0]      code_addr_o,
   output logic             code_valid_o,
   output logic [15:0]      jump_addr_o,
   output logic             jump_valid_o
);

   xag_ram_if ram_bus ();

   logic [15:0] ptr_q [2];
   logic        bank_sel_q;
   logic [1:0]  aux_spare_q;
   logic [1:0]  page_sel_q;
   logic [15:0] cur_ptr;
   logic [15:0] eff_addr;
   logic [15:0] ptr_plus_acc;
   logic        is_rd;
   logic        is_wr;
   logic        ptr_form;
   logic [7:0]  sfr_rd_d;

   function automatic logic in_range(input logic [15:0] a);
      return a < `XAG_RAM_LIMIT;
   endfunction : in_range

   function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : sfr_hit

   assign cur_ptr      = ptr_q[bank_sel_q];
   assign ptr_plus_acc = cur_ptr + {8'h00, acc_i};
   assign ptr_form     = (op_i == XAG_OP_PTR_RD) || (op_i == XAG_OP_PTR_WR);
   assign is_rd        = op_valid_i && ((op_i == XAG_OP_PTR_RD) || (op_i == XAG_OP_REG_RD));
   assign is_wr        = op_valid_i && ((op_i == XAG_OP_PTR_WR) || (op_i == XAG_OP_REG_WR));

   // upper page byte is zero-extended; page 3 lands out of range
   assign eff_addr = ptr_form ? cur_ptr : {6'h00, page_sel_q, ri_i};

   assign ram_bus.we    = is_wr && in_range(eff_addr);
   assign ram_bus.addr  = eff_addr[`XAG_RAM_AW-1:0];
   assign ram_bus.wdata = wdata_i;

   xag_ram u_ram (
      .ref_clk_i (ref_clk_i),
      .ram       (ram_bus.mem)
   );

   // data pointers; a pointer increment or load instruction wins over a same-cycle register write
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ptr_q[0] <= `XAG_RST_PTR;
         ptr_q[1] <= `XAG_RST_PTR;
      end else if (op_valid_i && (op_i == XAG_OP_PTR_INC)) begin
         ptr_q[bank_sel_q] <= cur_ptr + 16'h0001;
      end else if (op_valid_i && (op_i == XAG_OP_PTR_LOAD)) begin
         ptr_q[bank_sel_q] <= const16_i;
      end else if (sfr_wr_i && sfr_hit(sfr_addr_i, `XAG_OFS_PTR_LOW)) begin
         ptr_q[bank_sel_q][7:0] <= sfr_wdata_i;
      end else if (sfr_wr_i && sfr_hit(sfr_addr_i, `XAG_OFS_PTR_HIGH)) begin
         ptr_q[bank_sel_q][15:8] <= sfr_wdata_i;
      end
   end

   // auxiliary control: bank select plus two plain storage bits
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         bank_sel_q  <= `XAG_RST_BANK_SEL;
         aux_spare_q <= `XAG_RST_AUX_SPARE;
      end else if (sfr_wr_i && sfr_hit(sfr_addr_i, `XAG_OFS_AUX_CTRL_ONE)) begin
         bank_sel_q  <= sfr_wdata_i[`XAG_AUX_BANK_SEL_BIT];
         aux_spare_q <= sfr_wdata_i[`XAG_AUX_SPARE_MSB:`XAG_AUX_SPARE_LSB];
      end
   end

   // only the page bits are kept, so stray writes to 7-2 cannot stick
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         page_sel_q <= `XAG_RST_PAGE_SEL;
      end else if (sfr_wr_i && sfr_hit(sfr_addr_i, `XAG_OFS_PAGE_SEL)) begin
         page_sel_q <= sfr_wdata_i[`XAG_PAGE_SEL_MSB:0];
      end
   end

   // register read mux; unstored aux bits read as zero
   always_comb begin
      sfr_rd_d = `XAG_RST_BYTE;
      if (sfr_hit(sfr_addr_i, `XAG_OFS_PTR_LOW)) begin
         sfr_rd_d = cur_ptr[7:0];
      end else if (sfr_hit(sfr_addr_i, `XAG_OFS_PTR_HIGH)) begin
         sfr_rd_d = cur_ptr[15:8];
      end else if (sfr_hit(sfr_addr_i, `XAG_OFS_PAGE_SEL)) begin
         sfr_rd_d = {6'h00, page_sel_q};
      end else if (sfr_hit(sfr_addr_i, `XAG_OFS_AUX_CTRL_ONE)) begin
         sfr_rd_d = {2'h0, aux_spare_q, 3'h0, bank_sel_q};
      end
   end

   // read data holds until the next read
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= `XAG_RST_BYTE;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= sfr_rd_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         expanded_data_ram_rdata_o  <= `XAG_RST_BYTE;
         expanded_data_ram_rvalid_o <= 1'b0;
      end else begin
         expanded_data_ram_rvalid_o <= is_rd;
         if (is_rd) begin
            expanded_data_ram_rdata_o <= in_range(eff_addr) ? ram_bus.rdata : `XAG_RST_BYTE;
         end
      end
   end

   // code fetch and indirect jump targets for the core
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         code_addr_o  <= `XAG_RST_PTR;
         code_valid_o <= 1'b0;
         jump_addr_o  <= `XAG_RST_PTR;
         jump_valid_o <= 1'b0;
      end else begin
         code_valid_o <= op_valid_i && (op_i == XAG_OP_CODE_RD);
         jump_valid_o <= op_valid_i && (op_i == XAG_OP_JMP_IND);
         if (op_valid_i && (op_i == XAG_OP_CODE_RD)) begin
            code_addr_o <= ptr_plus_acc;
         end
         if (op_valid_i && (op_i == XAG_OP_JMP_IND)) begin
            jump_addr_o <= ptr_plus_acc;
         end
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking

   default disable iff (!rst_n_i);

   ptr_inc_a: assert property (
      op_valid_i && (op_i == XAG_OP_PTR_INC)
      |=> ptr_q[$past(bank_sel_q)] == $past(cur_ptr) + 16'h0001
   ) else $error("selected pointer did not increment");

   ptr_other_a: assert property (
      op_valid_i && (op_i == XAG_OP_PTR_LOAD)
      |=> (ptr_q[!$past(bank_sel_q)] == $past(ptr_q[!bank_sel_q]))
          && (ptr_q[$past(bank_sel_q)] == $past(const16_i))
   ) else $error("pointer load touched the wrong pointer");

   bank_sel_a: assert property (
      sfr_wr_i && (sfr_addr_i == `XAG_OFS_AUX_CTRL_ONE)
      |=> bank_sel_q == $past(sfr_wdata_i[0])
   ) else $error("bank select not taken from aux bit 0");

   ptr_high_rd_a: assert property (
      sfr_rd_i && (sfr_addr_i == `XAG_OFS_PTR_HIGH)
      |=> sfr_rdata_o == $past(cur_ptr[15:8])
   ) else $error("high byte read is not the selected pointer");

   ptr_low_wr_a: assert property (
      sfr_wr_i && (sfr_addr_i == `XAG_OFS_PTR_LOW) && !op_valid_i
      ##1 sfr_rd_i && (sfr_addr_i == `XAG_OFS_PTR_LOW) && $stable(bank_sel_q)
      |=> sfr_rdata_o == $past(sfr_wdata_i, 2)
   ) else $error("low byte did not read back");

   page_rsvd_a: assert property (
      sfr_rd_i && (sfr_addr_i == `XAG_OFS_PAGE_SEL)
      |=> sfr_rdata_o[7:2] == 6'h00
   ) else $error("page select reserved bits not zero");

   page_addr_a: assert property (
      op_valid_i && (op_i == XAG_OP_REG_WR) && (page_sel_q != 2'h3)
      |-> ram_bus.we && (ram_bus.addr == {page_sel_q, ri_i})
   ) else $error("paged write used wrong address");

   shared_store_a: assert property (
      op_valid_i && (op_i == XAG_OP_REG_WR) && in_range(eff_addr)
      ##1 op_valid_i && (op_i == XAG_OP_PTR_RD) && (cur_ptr == $past(eff_addr))
      |=> expanded_data_ram_rdata_o == $past(wdata_i, 2)
   ) else $error("paged write not seen through pointer");

   oob_read_a: assert property (
      is_rd && !in_range(eff_addr)
      |=> expanded_data_ram_rvalid_o && (expanded_data_ram_rdata_o == 8'h00)
   ) else $error("out of range read not zero");

   // an aliased low index must keep its byte when the full address is out of range
   oob_write_a: assert property (
      is_wr && !in_range(eff_addr) && (ram_bus.addr < `XAG_RAM_AW'(`XAG_RAM_BYTES))
      |=> u_ram.mem_q[$past(ram_bus.addr)] == $past(u_ram.mem_q[ram_bus.addr])
   ) else $error("out of range write reached storage");

   code_addr_a: assert property (
      op_valid_i && (op_i == XAG_OP_CODE_RD)
      |=> code_valid_o && (code_addr_o == $past(ptr_plus_acc)) ##1 !code_valid_o || $past(op_valid_i)
   ) else $error("code address not pointer plus acc");

endmodule : xag_top

`default_nettype wire

// ---- xag_top_tb.sv ----
// self-checking bench for the expanded ram address generator
`timescale 1ns/100ps
`default_nettype none
`include "xag_map.svh"

module xag_top_tb
   import xag_pkg::*;
;
   localparam logic [7:0] a_lo = `XAG_OFS_PTR_LOW;
   localparam logic [7:0] a_hi = `XAG_OFS_PTR_HIGH;
   localparam logic [7:0] a_pg = `XAG_OFS_PAGE_SEL;
   localparam logic [7:0] a_ax = `XAG_OFS_AUX_CTRL_ONE;
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic [7:0]  sfr_addr, sfr_wdata, acc, ri, wdata, sfr_rdata, expanded_data_ram_rdata;
   logic        sfr_wr, sfr_rd, op_valid, rvalid, code_valid, jump_valid;
   logic [15:0] c16, code_addr, jump_addr;
   xag_op_t     op;
   int          bad_count   = 0;
   int          comparisons = 0;

   always #25 ref_clk_i = ~ref_clk_i;

   xag_cpu cpu (.ref_clk_i(ref_clk_i), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd),
      .sfr_wdata_o(sfr_wdata), .op_valid_o(op_valid), .op_o(op), .const16_o(c16), .acc_o(acc),
      .ri_o(ri), .wdata_o(wdata));

   xag_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
      .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .op_valid_i(op_valid), .op_i(op), .const16_i(c16),
      .acc_i(acc), .ri_i(ri), .wdata_i(wdata), .sfr_rdata_o(sfr_rdata), .expanded_data_ram_rdata_o(expanded_data_ram_rdata),
      .expanded_data_ram_rvalid_o(rvalid), .code_addr_o(code_addr), .code_valid_o(code_valid),
      .jump_addr_o(jump_addr), .jump_valid_o(jump_valid));

   task automatic test_done();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      cpu.bus(1'b0, a, 8'h00);
      chk({8'h00, sfr_rdata}, {8'h00, e});
   endtask : rd

   // ram read; the valid pulse is only looked at in its single cycle
   task automatic xrd(input xag_op_t o, input logic [7:0] r, input logic [7:0] e);
      cpu.op(o, 16'h0000, 8'h00, r, 8'h00);
      chk({7'h00, rvalid, expanded_data_ram_rdata}, {8'h01, e});
   endtask : xrd

   task automatic ld(input logic [15:0] p);
      cpu.op(XAG_OP_PTR_LOAD, p, 8'h00, 8'h00, 8'h00);
   endtask : ld

   initial begin
      #(50 * 3000);
      bad_count++;
      test_done();
   end

   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(a_hi, 8'h00);
      rd(a_lo, 8'h00);
      rd(a_pg, 8'h00);
      rd(a_ax, 8'h00);
      rd(8'h90, 8'h00);
      cpu.bus(1'b1, a_hi, 8'h12);
      cpu.wr_rd(a_lo, 8'h34);
      chk({8'h00, sfr_rdata}, 16'h0034);
      rd(a_hi, 8'h12);
      rd(a_lo, 8'h34);
      cpu.bus(1'b1, a_ax, 8'h01);
      rd(a_ax, 8'h01);
      rd(a_hi, 8'h00);
      cpu.bus(1'b1, a_ax, 8'h00);
      rd(a_lo, 8'h34);
      // each page written through the register form, read back both ways
      for (int p = 0; p < 3; p++) begin
         cpu.bus(1'b1, a_pg, p[7:0]);
         ld({6'h00, p[1:0], 8'h10});
         cpu.op2(XAG_OP_REG_WR, 8'h10, 8'ha0 + p[7:0], XAG_OP_PTR_RD, 8'h00);
         chk({7'h00, rvalid, expanded_data_ram_rdata}, {8'h01, 8'ha0 + p[7:0]});
         xrd(XAG_OP_REG_RD, 8'h10, 8'ha0 + p[7:0]);
      end
      ld(16'h02ff);
      cpu.op(XAG_OP_PTR_WR, 16'h0000, 8'h00, 8'h00, 8'h5a);
      xrd(XAG_OP_REG_RD, 8'hff, 8'h5a);
      ld(16'h0000);
      cpu.op(XAG_OP_PTR_WR, 16'h0000, 8'h00, 8'h00, 8'h11);
      ld(16'h0400);
      cpu.op(XAG_OP_PTR_WR, 16'h0000, 8'h00, 8'h00, 8'h77);
      xrd(XAG_OP_PTR_RD, 8'h00, 8'h00);
      ld(16'h0000);
      xrd(XAG_OP_PTR_RD, 8'h00, 8'h11);
      cpu.bus(1'b1, a_pg, 8'h03);
      xrd(XAG_OP_REG_RD, 8'h00, 8'h00);
      // second pointer walks across a nibble boundary
      cpu.bus(1'b1, a_ax, 8'h01);
      ld(16'h010f);
      cpu.op(XAG_OP_PTR_INC, 16'h0000, 8'h00, 8'h00, 8'h00);
      rd(a_hi, 8'h01);
      rd(a_lo, 8'h10);
      xrd(XAG_OP_PTR_RD, 8'h00, 8'ha1);
      cpu.op(XAG_OP_CODE_RD, 16'h0000, 8'h10, 8'h00, 8'h00);
      chk(code_addr, 16'h0120);
      chk({15'h0000, code_valid}, 16'h0001);
      cpu.op(XAG_OP_JMP_IND, 16'h0000, 8'hf0, 8'h00, 8'h00);
      chk(jump_addr, 16'h0200);
      chk({15'h0000, jump_valid}, 16'h0001);
      cpu.bus(1'b1, a_ax, 8'h00);
      rd(a_hi, 8'h00);
      // mid-run reset after every register has been moved off its reset value
      ld(16'h5566);
      cpu.bus(1'b1, a_pg, 8'h02);
      cpu.bus(1'b1, a_ax, 8'hff);
      rd(a_ax, 8'h31);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(a_ax, 8'h00);
      rd(a_hi, 8'h00);
      rd(a_lo, 8'h00);
      rd(a_pg, 8'h00);
      test_done();
   end
endmodule : xag_top_tb

`default_nettype wire
